// ### pkg/pio_bus_pkg.sv
// Constants and types for the parallel asynchronous I/O bus master
package pio_bus_pkg;

  // Function-select codes, high level read as 1 (low = 0)
  typedef enum logic [2:0] {
    FN_STORE_BYTE = 3'h0,
    FN_FETCH      = 3'h1,
    FN_STORE_WORD = 3'h2,
    FN_RESET      = 3'h3,
    FN_POLL3      = 3'h4,
    FN_POLL2      = 3'h5,
    FN_POLL1      = 3'h6,
    FN_POLL0      = 3'h7
  } fn_type;

  // Processor-side command requests
  typedef enum logic [1:0] {
    CMD_FETCH = 2'h0,
    CMD_STORE = 2'h1,
    CMD_RESET = 2'h2
  } cmd_type;

  // Bus sequencer states, one bit changes per step from ST_IDLE to ST_DEAD and from ST_DGRANT to ST_DEND
  typedef enum logic [3:0] {
    ST_IDLE   = 4'h0,
    ST_SETUP  = 4'h1,
    ST_WAIT   = 4'h3,
    ST_REL    = 4'h2,
    ST_DEAD   = 4'h6,
    ST_DGRANT = 4'h7,
    ST_DWAIT  = 4'h5,
    ST_DADDR  = 4'h4,
    ST_DXFER  = 4'hC,
    ST_DEND   = 4'hD
  } state_type;

  localparam int CLK_PERIOD_NS   = 50;
  // Address/mode/data setup before the strobe, least 85 ns
  localparam int SETUP_NS        = 85;
  localparam int SETUP_CYC       =
    (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Response wait limit, 10 us, longest time rounds down
  localparam int TIMEOUT_US      = 10;
  localparam int TIMEOUT_CYC     = TIMEOUT_US * 1000 / CLK_PERIOD_NS;
  // Strobe dead time between cycles, 100 ns
  localparam int DEAD_NS         = 100;
  localparam int DEAD_CYC        =
    (DEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W           = 8;
  localparam logic [15:0] DATA_RESET = 16'h0000;

endpackage

// ### verilog/pio_bus_master.sv
// Processor-side sequencer of the parallel asynchronous I/O bus
`timescale 1ns/1ps

// Summary of operation
// - Bus lines active low, mode binary
// - Mode codes: stores, fetch, reset, polls
// - Fetch: address and mode before strobe
// - On response capture data, drop strobe
// - Word fetch full, byte to low byte
// - Store: address, mode, data before strobe
// - Store completes on response, strobe released
// - Hold bus stable up to 10 us
// - No response in 10 us: error
// - DMA request honoured after current cycle
// - Grant with strobe and poll-level-zero code
// - Chain responds, copy data to address
// - Restrobe for transfer, response ends grant
// - Four levels, bit seven highest priority
// - Sample requests at instruction end
// - Poll the highest pending level
// - Pick highest asserted low data bit
// - Word and byte, 64K byte space
// - Parallel levels above serial level
module pio_bus_master (
  input  wire logic        ref_clk,        // System clock, 20 MHz
  input  wire logic        rst_n,          // Asynchronous reset
  // Processor side
  input  wire logic        cmd_valid,      // Request a bus cycle
  input  wire logic [1:0]  cmd_kind,       // Fetch, store or reset
  input  wire logic        cmd_byte,       // Byte transfer when high
  input  wire logic [15:0] cmd_addr,       // Byte address
  input  wire logic [15:0] cmd_wdata,      // Store data
  output logic             cmd_ready,      // Sequencer idle
  output logic             cmd_done,       // Cycle finished pulse
  output logic [15:0]      cmd_rdata,      // Fetched data
  output logic             bus_error,      // Timeout pulse
  input  wire logic        instr_end,      // End of instruction
  input  wire logic        serial_irq,     // Serial bus request
  output logic             irq_valid,      // Interrupt vector pulse
  output logic [2:0]       irq_level,      // 4 = serial level
  output logic [2:0]       irq_bit,        // Winning device bit
  output logic             dma_active,     // Bus lent to DMA
  // Bus pins, all active low except the mode lines
  output logic [15:0]      bus_address_lines_n,
  input  wire logic [15:0] bus_data_lines_n_in,
  output logic [15:0]      bus_data_lines_n_out,
  output logic [15:0]      bus_data_lines_n_oe,
  output logic [2:0]       bus_mode,
  output logic             bus_init_n,
  input  wire logic        cycle_response_n,
  input  wire logic        dma_request_line_n,
  output logic             dma_grant_line_n,
  input  wire logic [3:0]  parallel_irq_line_n
);

  pio_bus_pkg::state_type  state_q;      // Sequencer state
  logic [pio_bus_pkg::CNT_W-1:0] cnt_q;  // Setup/dead counter
  logic [8:0]              tmo_q;        // Response wait counter
  logic [15:0]             addr_q;       // Driven address
  logic [15:0]             wdata_q;      // Driven data
  logic                    drive_q;      // Data lines driven
  logic [2:0]              mode_q;       // Driven mode code
  logic                    init_q;       // Strobe asserted
  logic                    grant_q;      // Grant asserted
  logic                    fetch_q;      // Current cycle is a fetch
  logic                    poll_q;       // Current cycle is a poll
  logic                    byte_q;       // Byte transfer
  logic                    addr_lo_q;    // Byte lane select
  logic [1:0]              poll_lvl_q;   // Level being polled
  logic                    irq_pend_q;   // Poll scheduled
  logic                    rsp;          // Response, active high
  logic [15:0]             din;          // Data lines, active high
  logic [3:0]              irq_req;      // Levels requesting
  logic [2:0]              win_bit;      // Priority bit encoder
  logic                    win_any;      // Any bit asserted

  // Invert the active-low pins once at the edge
  assign rsp     = ~cycle_response_n;
  assign din     = ~bus_data_lines_n_in;
  assign irq_req = ~parallel_irq_line_n;

  // Bus pins from registers; open collector drives low only
  assign bus_address_lines_n  = ~addr_q;
  assign bus_data_lines_n_out = 16'h0000;
  assign bus_data_lines_n_oe  = drive_q ? wdata_q : 16'h0000;
  assign bus_mode             = mode_q;
  assign bus_init_n           = ~init_q;
  assign dma_grant_line_n     = ~grant_q;
  assign cmd_ready  = (state_q == pio_bus_pkg::ST_IDLE) && !irq_pend_q;
  assign dma_active = grant_q;

  // Highest asserted low data bit wins, bit 7 first
  always_comb begin
    win_bit = 3'h0;
    win_any = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (din[i]) begin
        win_bit = 3'(i);
        win_any = 1'b1;
      end
    end
  end

  // Interrupt scheduling at the end of an instruction
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_pend_q <= 1'b0;
      poll_lvl_q <= 2'h0;
    end else if (state_q == pio_bus_pkg::ST_IDLE && instr_end &&
                 !irq_pend_q && irq_req != 4'h0) begin
      irq_pend_q <= 1'b1;
      // Highest level first
      if (irq_req[3])      poll_lvl_q <= 2'h3;
      else if (irq_req[2]) poll_lvl_q <= 2'h2;
      else if (irq_req[1]) poll_lvl_q <= 2'h1;
      else                 poll_lvl_q <= 2'h0;
    end else if (state_q == pio_bus_pkg::ST_SETUP && poll_q) begin
      irq_pend_q <= 1'b0;
    end
  end

  // Main bus sequencer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q   <= pio_bus_pkg::ST_IDLE;
      cnt_q     <= '0;
      tmo_q     <= '0;
      addr_q    <= 16'h0000;
      wdata_q   <= pio_bus_pkg::DATA_RESET;
      drive_q   <= 1'b0;
      mode_q    <= pio_bus_pkg::FN_POLL0;
      init_q    <= 1'b0;
      grant_q   <= 1'b0;
      fetch_q   <= 1'b0;
      poll_q    <= 1'b0;
      byte_q    <= 1'b0;
      addr_lo_q <= 1'b0;
      cmd_rdata <= pio_bus_pkg::DATA_RESET;
      cmd_done  <= 1'b0;
      bus_error <= 1'b0;
      irq_valid <= 1'b0;
      irq_level <= 3'h0;
      irq_bit   <= 3'h0;
    end else begin
      cmd_done  <= 1'b0;
      bus_error <= 1'b0;
      irq_valid <= 1'b0;
      case (state_q)
        pio_bus_pkg::ST_IDLE: begin
          cnt_q <= '0;
          tmo_q <= '0;
          if (!dma_request_line_n) begin
            // DMA granted between cycles
            mode_q  <= pio_bus_pkg::FN_POLL0;
            drive_q <= 1'b0;
            grant_q <= 1'b1;
            state_q <= pio_bus_pkg::ST_DGRANT;
          end else if (irq_pend_q) begin
            poll_q  <= 1'b1;
            fetch_q <= 1'b0;
            drive_q <= 1'b0;
            // Poll code for the chosen level
            mode_q  <= 3'h7 - {1'b0, poll_lvl_q};
            state_q <= pio_bus_pkg::ST_SETUP;
          end else if (instr_end && serial_irq && irq_req == 4'h0) begin
            // Serial level only when no parallel level waits
            irq_valid <= 1'b1;
            irq_level <= 3'h4;
            irq_bit   <= 3'h0;
          end else if (cmd_valid) begin
            // Lines set before the strobe
            poll_q    <= 1'b0;
            addr_q    <= cmd_addr;
            addr_lo_q <= cmd_addr[0];
            byte_q    <= cmd_byte;
            wdata_q   <= cmd_wdata;
            fetch_q   <= (cmd_kind == pio_bus_pkg::CMD_FETCH);
            drive_q   <= (cmd_kind == pio_bus_pkg::CMD_STORE);
            if (cmd_kind == pio_bus_pkg::CMD_FETCH)
              mode_q <= pio_bus_pkg::FN_FETCH;
            else if (cmd_kind == pio_bus_pkg::CMD_STORE)
              mode_q <= cmd_byte ? pio_bus_pkg::FN_STORE_BYTE
                                 : pio_bus_pkg::FN_STORE_WORD;
            else
              mode_q <= pio_bus_pkg::FN_RESET;
            state_q <= pio_bus_pkg::ST_SETUP;
          end
        end
        pio_bus_pkg::ST_SETUP: begin
          // Hold setup time, then assert the strobe
          if (cnt_q == pio_bus_pkg::CNT_W'(pio_bus_pkg::SETUP_CYC - 1)) begin
            init_q  <= 1'b1;
            cnt_q   <= '0;
            state_q <= pio_bus_pkg::ST_WAIT;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        pio_bus_pkg::ST_WAIT: begin
          // Lines stay stable while waiting
          if (rsp) begin
            init_q  <= 1'b0;
            if (poll_q) begin
              irq_valid <= win_any;
              irq_level <= {1'b0, poll_lvl_q};
              irq_bit   <= win_bit;
            end else if (fetch_q) begin
              // Word whole, byte lane to low byte
              if (!byte_q)
                cmd_rdata <= din;
              else if (addr_lo_q)
                cmd_rdata <= {8'h00, din[15:8]};
              else
                cmd_rdata <= {8'h00, din[7:0]};
            end
            cmd_done <= !poll_q;
            state_q  <= pio_bus_pkg::ST_REL;
          end else if (tmo_q == 9'(pio_bus_pkg::TIMEOUT_CYC - 1)) begin
            // No answer within 10 us
            init_q    <= 1'b0;
            bus_error <= 1'b1;
            cmd_done  <= !poll_q;
            state_q   <= pio_bus_pkg::ST_REL;
          end else begin
            tmo_q <= tmo_q + 1'b1;
          end
        end
        pio_bus_pkg::ST_REL: begin
          drive_q <= 1'b0;
          cnt_q   <= '0;
          state_q <= pio_bus_pkg::ST_DEAD;
        end
        pio_bus_pkg::ST_DEAD: begin
          // Strobe dead time before the next cycle
          if (cnt_q == pio_bus_pkg::CNT_W'(pio_bus_pkg::DEAD_CYC - 1)) begin
            state_q <= pio_bus_pkg::ST_IDLE;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        pio_bus_pkg::ST_DGRANT: begin
          init_q  <= 1'b1;
          tmo_q   <= '0;
          state_q <= pio_bus_pkg::ST_DWAIT;
        end
        pio_bus_pkg::ST_DWAIT: begin
          if (rsp) begin
            // Chain end answered: take DMA address
            init_q  <= 1'b0;
            addr_q  <= din;
            state_q <= pio_bus_pkg::ST_DADDR;
          end else if (tmo_q == 9'(pio_bus_pkg::TIMEOUT_CYC - 1)) begin
            init_q    <= 1'b0;
            grant_q   <= 1'b0;
            bus_error <= 1'b1;
            state_q   <= pio_bus_pkg::ST_REL;
          end else begin
            tmo_q <= tmo_q + 1'b1;
          end
        end
        pio_bus_pkg::ST_DADDR: begin
          // Mode held at poll-level-zero code, wait dead time and response release, then restrobe
          if (cnt_q == pio_bus_pkg::CNT_W'(pio_bus_pkg::DEAD_CYC - 1)) begin
            if (!rsp) begin
              init_q  <= 1'b1;
              tmo_q   <= '0;
              state_q <= pio_bus_pkg::ST_DXFER;
            end
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        pio_bus_pkg::ST_DXFER: begin
          if (rsp || tmo_q == 9'(pio_bus_pkg::TIMEOUT_CYC - 1)) begin
            // Response withdraws the grant
            bus_error <= !rsp;
            init_q    <= 1'b0;
            grant_q   <= 1'b0;
            state_q   <= pio_bus_pkg::ST_DEND;
          end else begin
            tmo_q <= tmo_q + 1'b1;
          end
        end
        pio_bus_pkg::ST_DEND: begin
          mode_q  <= pio_bus_pkg::FN_POLL0;
          cnt_q   <= '0;
          state_q <= pio_bus_pkg::ST_DEAD;
        end
        default: begin
          state_q <= pio_bus_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Strobe rises only after the setup count
  a_setup_before_init: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    $rose(init_q) && !grant_q |-> $past(state_q) == pio_bus_pkg::ST_SETUP)
    else $error("Strobe raised without setup");

  // Bus stable while waiting
  a_stable_wait: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    state_q == pio_bus_pkg::ST_WAIT && $past(state_q) ==
      pio_bus_pkg::ST_WAIT |-> $stable(addr_q) && $stable(mode_q))
    else $error("Bus changed during wait");

  // Response drops the strobe next cycle
  a_rsp_release: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    state_q == pio_bus_pkg::ST_WAIT && rsp |=> !init_q)
    else $error("Strobe held after response");

  // Timeout flags an error exactly at the limit
  a_timeout_err: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    bus_error |-> $past(tmo_q) == 9'(pio_bus_pkg::TIMEOUT_CYC - 1))
    else $error("Error without full wait");

  // Grant comes with the poll-level-zero code
  a_grant_mode: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    $rose(grant_q) |-> mode_q == pio_bus_pkg::FN_POLL0)
    else $error("Grant with wrong mode");

  // DMA transfer response withdraws grant
  a_grant_drop: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    state_q == pio_bus_pkg::ST_DXFER && rsp |=> !grant_q)
    else $error("Grant held after transfer");

  // Captured DMA address appears on address lines
  a_dma_addr: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    state_q == pio_bus_pkg::ST_DWAIT && rsp |=> addr_q == $past(din))
    else $error("DMA address not copied");

  // Byte fetch clears the upper byte
  a_byte_fetch: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    cmd_done && fetch_q && byte_q && !bus_error |-> cmd_rdata[15:8] == 8'h00)
    else $error("Byte fetch upper byte set");

endmodule

// ### dv/pio_bus_peripheral.sv
// Behavioural far-side model: peripheral, memory, DMA device, interrupts
`timescale 1ns/1ps
module pio_bus_peripheral (
  input  wire logic        ref_clk,             // System clock
  input  wire logic        rst_n,               // Async reset
  input  wire logic [15:0] bus_data_lines_n,    // Resolved data wire
  input  wire logic [2:0]  bus_mode,            // Function code
  input  wire logic        bus_init_n,          // Cycle strobe
  input  wire logic        dma_grant_line_n,    // DMA grant
  input  wire logic [15:0] fetch_data,          // Data a fetch returns
  input  wire logic [15:0] dma_addr,            // DMA transfer address
  input  wire logic [7:0]  delay,               // Response delay
  input  wire logic        mute,                // Never respond
  input  wire logic        dma_want,            // Want the bus
  input  wire logic [3:0]  irq_lvls,            // Levels requesting
  input  wire logic [7:0]  irq_bits,            // Device bits on poll
  output logic [15:0]      per_oe,              // Pulls data bit low
  output logic             cycle_response_n,    // Response
  output logic             dma_request_line_n,  // DMA request
  output logic [3:0]       parallel_irq_line_n, // Interrupt requests
  output logic [15:0]      stored               // Last stored value
);
  logic        rsp_q;  // Response held low once given
  logic [15:0] oe_q;   // Data drive while strobe low
  logic [7:0]  cnt_q;  // Access time counter
  logic        dph_q;  // DMA address phase done
  logic [15:0] drive;  // Value to put on the data lines

  assign dma_request_line_n  = ~dma_want;
  assign parallel_irq_line_n = ~irq_lvls;
  // Data and response vanish with the strobe
  assign per_oe           = bus_init_n ? 16'h0000 : oe_q;
  assign cycle_response_n = rsp_q | bus_init_n;

  // Pick what the addressed party places on the data lines
  always_comb begin
    if (!dma_grant_line_n) begin
      drive = dph_q ? fetch_data : dma_addr;
    end else if (bus_mode >= 3'h4) begin
      drive = irq_lvls[2'(3'h7 - bus_mode)] ?
              {8'h00, irq_bits} : 16'h0000;
    end else if (bus_mode == pio_bus_pkg::FN_FETCH) begin
      drive = fetch_data;
    end else begin
      drive = 16'h0000;
    end
  end

  // Respond after the access time, latch stores on the response
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_q  <= 1'b1;
      oe_q   <= 16'h0000;
      cnt_q  <= 8'h00;
      dph_q  <= 1'b0;
      stored <= 16'h0000;
    end else if (bus_init_n) begin
      rsp_q <= 1'b1;
      oe_q  <= 16'h0000;
      cnt_q <= 8'h00;
      if (dma_grant_line_n) begin
        dph_q <= 1'b0;
      end
    end else if (!mute && rsp_q) begin
      oe_q <= drive;
      if (cnt_q == delay) begin
        rsp_q <= 1'b0;
        if (!dma_grant_line_n) begin
          dph_q <= 1'b1;
        end
        if (bus_mode == pio_bus_pkg::FN_STORE_WORD) begin
          stored <= ~bus_data_lines_n;
        end else if (bus_mode == pio_bus_pkg::FN_STORE_BYTE) begin
          stored <= {8'h00, ~bus_data_lines_n[7:0]};
        end
      end else begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end
endmodule

// ### dv/parallel_async_io_bus_tb.sv
// Self-checking bench for the parallel I/O bus sequencer
`timescale 1ns/1ps
module parallel_async_io_bus_tb;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cmd_valid = 1'b0, cmd_byte = 1'b0, instr_end = 1'b0;
  logic        serial_irq = 1'b0, mute = 1'b0, dma_want = 1'b0;
  logic [1:0]  cmd_kind = 2'h0;
  logic [15:0] cmd_addr = 16'h0000, cmd_wdata = 16'h0000;
  logic [15:0] fetch_data = 16'h0000, dma_addr = 16'h0000;
  logic [7:0]  delay = 8'h00, irq_bits = 8'h00;
  logic [3:0]  irq_lvls = 4'h0;
  logic        cmd_ready, cmd_done, bus_error, irq_valid, dma_active;
  logic        bus_init_n, cycle_response_n, dma_request_line_n;
  logic        dma_grant_line_n, first, err;
  logic [15:0] cmd_rdata, bus_address_lines_n, uut_out, uut_oe, per_oe;
  logic [15:0] data_n, stored, seen_addr;
  logic [2:0]  irq_level, irq_bit, bus_mode, seen_mode;
  logic [3:0]  parallel_irq_line_n;
  int          n_fail = 0, samples_checked = 0, wcyc;

  always #25 ref_clk = ~ref_clk;
  // Open-collector wire with pull-up
  assign data_n = ~(uut_oe | per_oe);

  pio_bus_master uut (.ref_clk(ref_clk), .rst_n(rst_n),
    .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_byte(cmd_byte),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
    .cmd_done(cmd_done), .cmd_rdata(cmd_rdata), .bus_error(bus_error),
    .instr_end(instr_end), .serial_irq(serial_irq),
    .irq_valid(irq_valid), .irq_level(irq_level), .irq_bit(irq_bit),
    .dma_active(dma_active), .bus_address_lines_n(bus_address_lines_n),
    .bus_data_lines_n_in(data_n), .bus_data_lines_n_out(uut_out),
    .bus_data_lines_n_oe(uut_oe), .bus_mode(bus_mode),
    .bus_init_n(bus_init_n), .cycle_response_n(cycle_response_n),
    .dma_request_line_n(dma_request_line_n),
    .dma_grant_line_n(dma_grant_line_n),
    .parallel_irq_line_n(parallel_irq_line_n));

  pio_bus_peripheral far (.ref_clk(ref_clk), .rst_n(rst_n),
    .bus_data_lines_n(data_n), .bus_mode(bus_mode),
    .bus_init_n(bus_init_n), .dma_grant_line_n(dma_grant_line_n),
    .fetch_data(fetch_data), .dma_addr(dma_addr), .delay(delay),
    .mute(mute), .dma_want(dma_want), .irq_lvls(irq_lvls),
    .irq_bits(irq_bits), .per_oe(per_oe),
    .cycle_response_n(cycle_response_n),
    .dma_request_line_n(dma_request_line_n),
    .parallel_irq_line_n(parallel_irq_line_n), .stored(stored));

  // Compare one result and count it
  task automatic chk(input string what, input logic [15:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Watch the bus at falling edges until the awaited event, bounded
  task automatic watch(input int what);
    int   i;
    logic hit;
    first = 1'b1;
    err = 1'b0;
    wcyc = 0;
    hit = 1'b0;
    for (i = 0; i < 2000 && !hit; i++) begin
      @(negedge ref_clk);
      if (!bus_init_n) begin
        if (first) seen_mode = bus_mode;
        first = 1'b0;
        seen_addr = ~bus_address_lines_n;
        wcyc++;
      end
      if (bus_error) err = 1'b1;
      if (dma_active) dma_want <= 1'b0;
      case (what)
        0: hit = cmd_done;
        1: hit = irq_valid;
        2: hit = !dma_active && !first;
        default: hit = cmd_ready;
      endcase
    end
    if (!hit) chk("handshake", 16'h0001, 16'h0000);
  endtask

  // One processor request, held until the edge that takes it
  task automatic run_cmd(input logic [1:0] k, input logic b,
                         input logic [15:0] a, w);
    watch(3);
    @(posedge ref_clk);
    cmd_kind <= k;
    cmd_byte <= b;
    cmd_addr <= a;
    cmd_wdata <= w;
    cmd_valid <= 1'b1;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    watch(0);
  endtask

  // Fetch with a given access time and expected result
  task automatic fetch_case(input logic b, input logic [15:0] a, d,
                            input logic [7:0] dl, input logic [15:0] m,
                            input logic [15:0] e);
    fetch_data <= d;
    delay <= dl;
    run_cmd(2'h0, b, a, 16'h0000);
    chk("fetch mode", 16'h0001, {13'h0, seen_mode});
    chk("fetch addr", a, seen_addr);
    chk("fetch data", e, cmd_rdata & m);
    chk("fetch no error", 16'h0000, {15'h0, err});
  endtask

  task automatic t_stores;
    run_cmd(2'h1, 1'b0, 16'h8002, 16'hBEEF);
    chk("store word mode", 16'h0002, {13'h0, seen_mode});
    chk("store word", 16'hBEEF, stored);
    run_cmd(2'h1, 1'b1, 16'h8003, 16'h1234);
    chk("store byte mode", 16'h0000, {13'h0, seen_mode});
    chk("store byte", 16'h0034, stored);
    run_cmd(2'h2, 1'b0, 16'h0000, 16'h0000);
    chk("reset mode", 16'h0003, {13'h0, seen_mode});
    $display("test stores done");
  endtask

  task automatic t_timeout;
    mute <= 1'b1;
    run_cmd(2'h0, 1'b0, 16'h0100, 16'h0000);
    chk("timeout error", 16'h0001, {15'h0, err});
    chk("wait held", 16'h0001, {15'h0, wcyc >= 200});
    mute <= 1'b0;
    $display("test timeout done");
  endtask

  task automatic t_dma;
    dma_addr <= 16'h4C20;
    fetch_data <= 16'h0F0F;
    @(posedge ref_clk);
    dma_want <= 1'b1;
    watch(2);
    chk("grant mode", 16'h0007, {13'h0, seen_mode});
    chk("dma addr", 16'h4C20, seen_addr);
    chk("grant released", 16'h0001, {15'h0, dma_grant_line_n});
    $display("test dma done");
  endtask

  // Raise requests, end an instruction, check the vector chosen
  task automatic poll_case(input logic [3:0] l, input logic [7:0] b,
                           input logic s, input logic [2:0] el, eb);
    irq_lvls <= l;
    irq_bits <= b;
    // Wait for idle so the instruction end is not lost in dead time
    watch(3);
    @(posedge ref_clk);
    serial_irq <= s;
    instr_end <= 1'b1;
    @(posedge ref_clk);
    instr_end <= 1'b0;
    watch(1);
    if (el != 3'h4)
      chk("poll mode", 16'(3'h7 - el), 16'(seen_mode));
    chk("irq level", {13'h0, el}, {13'h0, irq_level});
    chk("irq bit", {13'h0, eb}, {13'h0, irq_bit});
    @(posedge ref_clk);
    irq_lvls <= 4'h0;
    serial_irq <= 1'b0;
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    fetch_case(1'b0, 16'h1234, 16'hA55A, 8'h00, 16'hFFFF, 16'hA55A);
    fetch_case(1'b1, 16'h0FF1, 16'h3C00, 8'h14, 16'hFFFF, 16'h003C);
    fetch_case(1'b1, 16'h0FF0, 16'h00C3, 8'h02, 16'hFFFF, 16'h00C3);
    $display("test fetch done");
    t_stores;
    t_timeout;
    t_dma;
    poll_case(4'h6, 8'h28, 1'b0, 3'h2, 3'h5);
    poll_case(4'hF, 8'h81, 1'b0, 3'h3, 3'h7);
    poll_case(4'h1, 8'h01, 1'b0, 3'h0, 3'h0);
    poll_case(4'h2, 8'h10, 1'b1, 3'h1, 3'h4);
    poll_case(4'h0, 8'h00, 1'b1, 3'h4, 3'h0);
    $display("test poll done");
    complete_run;
  end

  // Watchdog well beyond the expected run length
  initial begin
    #(20000 * 50);
    n_fail++;
    complete_run;
  end
endmodule
